// [core/tfdc_pkg.sv]
// Constants and types shared by the fan drive control block
// Function
// - Analog drive code register is unsigned 8-bit, resetting to all ones (full speed).
// - Analog output spans 0 to 2.5 V as code over 256.
// - Pulse output runs near 75 Hz; manual duty comes from pulse register.
// - Pulse output is open drain; test bit 1 inverts polarity.
// - Automatic control works only while monitoring bit 0 is set.
// - Config bit 5 automates analog output, bit 6 the pulse output.
// - Three signed start thresholds: local sensor and two remote sensors.
// - Automatic analog minimum is 16 times analog register upper nibble.
// - Automatic pulse minimum duty is 6.67 percent times pulse register nibble.
// - With both automatic enables, analog nibble sets both minimums.
// - On start, drive full scale for two seconds, then the highest channel demand.
// - Duty rises linearly with excess temperature over a 20 degree span.
// - Analog code ramps to 240 over the span, then jumps to 255.
// - Applied drive is the highest demand among all channels.
// - Fan stops when all sensors are four degrees below threshold, or at once when automatic control is turned off.
// - Every automatic fan start or stop raises one interrupt event.
// - Interrupt output drives only while config bit 1 is set.
// - Temperatures and thresholds compare as signed twos-complement degrees.
`default_nettype none
package tfdc_pkg;
	localparam logic [7:0] ADDR_CONFIG      = 8'h00;
	localparam logic [7:0] ADDR_DAC_CODE    = 8'h04;
	localparam logic [7:0] ADDR_PWM_DUTY    = 8'h05;
	localparam logic [7:0] ADDR_START_TEMP_LOCAL_LOCAL  = 8'h10;
	localparam logic [7:0] ADDR_START_TEMP_LOCAL_REM_A  = 8'h11;
	localparam logic [7:0] ADDR_START_TEMP_LOCAL_REM_B  = 8'h12;
	localparam logic [7:0] ADDR_TEST        = 8'h14;
	localparam int         CFG_MONITOR_BIT  = 0;
	localparam int         CFG_INT_EN_BIT   = 1;
	localparam int         CFG_INT_CLR_BIT  = 2;
	localparam int         CFG_AUTO_DAC_BIT = 5;
	localparam int         CFG_AUTO_PWM_BIT = 6;
	localparam int         TEST_INVERT_BIT  = 1;
	localparam int         TEST_PIN_BIT     = 7;
	localparam logic [7:0] CONFIG_RESET     = 8'h00;
	localparam logic [7:0] DAC_RESET        = 8'hFF;
	localparam logic [7:0] PWM_RESET        = 8'h00;
	localparam logic [7:0] START_TEMP_LOCAL_RESET       = 8'h7F;
	localparam logic [7:0] TEST_RESET       = 8'h00;
	localparam logic [7:0] TEMP_RESET       = 8'h80;
	localparam logic [7:0] CODE_FULL        = 8'hFF;
	localparam logic [7:0] CODE_OFF         = 8'h00;
	localparam logic [7:0] DAC_RAMP_TOP     = 8'hF0;
	localparam logic [7:0] PWM_RAMP_TOP     = 8'hFF;
	localparam logic [7:0] DAC_MIN_STEP     = 8'h10;
	localparam logic [7:0] PWM_MIN_STEP     = 8'h11;
	localparam logic [8:0] RAMP_SPAN_DEG    = 9'h014;
	localparam logic [8:0] HYST_DEG         = 9'h004;
	localparam int         NUM_CHANNELS     = 3;
	localparam longint     CLK_HZ           = 25000000;
	localparam longint     PWM_FREQ_HZ      = 75;
	localparam longint     PWM_PHASES       = 256;
	localparam longint     SPINUP_S         = 2;
	localparam int         PWM_STEP_CYCLES  = int'(CLK_HZ / (PWM_FREQ_HZ * PWM_PHASES));
	localparam int         SPINUP_CYCLES    = int'(SPINUP_S * CLK_HZ);
	typedef enum logic [1:0] {
		CHAN_LOCAL,
		CHAN_REMOTE_A,
		CHAN_REMOTE_B
	} tfdc_chan_t;
endpackage : tfdc_pkg
`default_nettype wire

// [core/tfdc_pwm_if.sv]
// Carrier between the drive controller and the pulse generator
`timescale 1ns/10ps
`default_nettype none
interface tfdc_pwm_if;
	logic [7:0] duty;
	logic       invert;
	logic       pull;
	modport ctrl (output duty, output invert, input pull);
	modport gen  (input duty, input invert, output pull);
endinterface : tfdc_pwm_if
`default_nettype wire

// [core/tfdc_pwm_gen.sv]
// Pulse generator with prescaled 256-phase period
`timescale 1ns/10ps
`default_nettype none
module tfdc_pwm_gen #(
	parameter int unsigned STEP_CYCLES = tfdc_pkg::PWM_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Duty and polarity in, pulldown out
	tfdc_pwm_if.gen  pwm
);
	localparam int STEP_W = $clog2(STEP_CYCLES);
	generate
		if (STEP_CYCLES < 2) begin : g_bad_step
			$error("STEP_CYCLES must be at least 2");
		end
	endgenerate
	typedef struct packed {
		logic [STEP_W-1:0] step;
		logic [7:0]        phase;
		logic              pull;
	} tfdc_pwm_state_t;
	tfdc_pwm_state_t s;
	tfdc_pwm_state_t next_s;
	logic            on_phase;
	always_comb begin
		next_s = s;
		if (s.step == STEP_W'(STEP_CYCLES - 1)) begin
			next_s.step  = '0;
			next_s.phase = s.phase + 8'h01;
		end else begin
			next_s.step = s.step + STEP_W'(1);
		end
		on_phase = (pwm.duty == tfdc_pkg::CODE_FULL) || (s.phase < pwm.duty);
		next_s.pull = ~(on_phase ^ pwm.invert);
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// Pin held pulled down so no stray pulse follows reset
			s <= '{step: '0, phase: 8'h00, pull: 1'b1};
		end else begin
			s <= next_s;
		end
	end
	assign pwm.pull = s.pull;
endmodule : tfdc_pwm_gen
`default_nettype wire

// [core/tfdc_chan_demand.sv]
// Per-channel start, stop and drive demand evaluation
`timescale 1ns/10ps
`default_nettype none
module tfdc_chan_demand (
	// Channel temperature and threshold
	input  wire logic [7:0] temp,
	input  wire logic [7:0] start_temp_local,
	// Minimum drive codes
	input  wire logic [7:0] dac_min,
	input  wire logic [7:0] pwm_min,
	// Results
	output logic            above,
	output logic            cool,
	output logic [7:0]      dac_dem,
	output logic [7:0]      pwm_dem
);
	logic signed [8:0] excess;
	function automatic logic [7:0] ramp(input logic [7:0] lo, input logic [7:0] hi,
			input logic [4:0] ex);
		logic [12:0] prod;
		prod = 13'(hi - lo) * 13'(ex);
		ramp = lo + 8'(prod / 13'(tfdc_pkg::RAMP_SPAN_DEG));
	endfunction : ramp
	always_comb begin
		excess = $signed({temp[7], temp}) - $signed({start_temp_local[7], start_temp_local});
		// threshold 127 can never be exceeded
		above  = excess > 9'sd0;
		cool   = excess <= -$signed(tfdc_pkg::HYST_DEG);
		if (excess <= 9'sd0) begin
			dac_dem = dac_min;
			pwm_dem = pwm_min;
		end else if (excess > $signed(tfdc_pkg::RAMP_SPAN_DEG)) begin
			dac_dem = tfdc_pkg::CODE_FULL;
			pwm_dem = tfdc_pkg::CODE_FULL;
		end else begin
			dac_dem = ramp(dac_min, tfdc_pkg::DAC_RAMP_TOP, excess[4:0]);
			pwm_dem = ramp(pwm_min, tfdc_pkg::PWM_RAMP_TOP, excess[4:0]);
		end
	end
endmodule : tfdc_chan_demand
`default_nettype wire

// [core/tfdc_core.sv]
// Fan drive control: registers, automatic control and output drive
`timescale 1ns/10ps
`default_nettype none
module tfdc_core #(
	parameter int unsigned SPINUP_CYCLES = tfdc_pkg::SPINUP_CYCLES,
	parameter int unsigned PWM_STEP      = tfdc_pkg::PWM_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RESET_N,
	// Register port
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WRITE,
	output logic [7:0]      REG_RDATA,
	// Temperature results
	input  wire logic       TEMP_VALID,
	input  wire logic [1:0] TEMP_CHANNEL,
	input  wire logic [7:0] TEMP_DATA,
	// Analog drive code
	output logic [7:0]      DAC_CODE,
	// Open-drain pulse pin
	input  wire logic       PWM_IN,
	output logic            PWM_OUT,
	output logic            PWM_OE,
	// Interrupt and status
	output logic            INT_N,
	output logic            FAN_RUNNING
);
	localparam int NCH    = tfdc_pkg::NUM_CHANNELS;
	localparam int SPIN_W = $clog2(SPINUP_CYCLES + 1);

	generate
		if (SPINUP_CYCLES < 1) begin : g_bad_spin
			$error("SPINUP_CYCLES must be at least 1");
		end
		// Prescaler below two leaves no room for the step counter
		if (PWM_STEP < 2) begin : g_bad_pwm_step
			$error("PWM_STEP must be at least 2");
		end
	endgenerate

	typedef struct packed {
		// Host registers
		logic [7:0]           cfg;
		logic [7:0]           dac_reg;
		logic [7:0]           pwm_reg;
		logic [7:0]           test_reg;
		logic [NCH-1:0][7:0]  start_temp_local;
		// Stored results and automatic state
		logic [NCH-1:0][7:0]  temp;
		logic                 upd;
		logic                 fan_on;
		logic                 spin;
		logic [SPIN_W-1:0]    spin_cnt;
		logic [7:0]           auto_dac;
		logic [7:0]           auto_pwm;
		logic                 evt;
		// Pin filter
		logic [2:0]           pin_sync;
		logic                 pin_level;
		// Registered outputs
		logic [7:0]           dac_out;
		logic [7:0]           pwm_duty;
		logic                 invert;
		logic [7:0]           rdata;
		logic                 int_n;
		logic                 pwm_oe;
		logic                 pwm_out;
	} tfdc_state_t;

	// Register select, one decode for writes and readback
	typedef enum logic [2:0] {
		SEL_CONFIG,
		SEL_DAC,
		SEL_PWM,
		SEL_START_TEMP_LOCAL_LOCAL,
		SEL_START_TEMP_LOCAL_REM_A,
		SEL_START_TEMP_LOCAL_REM_B,
		SEL_TEST,
		SEL_NONE
	} tfdc_sel_t;

	localparam tfdc_state_t RESET_STATE = '{
		cfg:       tfdc_pkg::CONFIG_RESET,
		dac_reg:   tfdc_pkg::DAC_RESET,
		pwm_reg:   tfdc_pkg::PWM_RESET,
		test_reg:  tfdc_pkg::TEST_RESET,
		start_temp_local:      {NCH{tfdc_pkg::START_TEMP_LOCAL_RESET}},
		temp:      {NCH{tfdc_pkg::TEMP_RESET}},
		upd:       1'b0,
		fan_on:    1'b0,
		spin:      1'b0,
		spin_cnt:  '0,
		auto_dac:  tfdc_pkg::CODE_OFF,
		auto_pwm:  tfdc_pkg::CODE_OFF,
		evt:       1'b0,
		pin_sync:  3'h7,
		pin_level: 1'b1,
		dac_out:   tfdc_pkg::DAC_RESET,
		pwm_duty:  tfdc_pkg::PWM_RESET,
		invert:    1'b0,
		rdata:     8'h00,
		int_n:     1'b1,
		pwm_oe:    1'b1,
		pwm_out:   1'b0
	};

	tfdc_state_t s;
	tfdc_state_t next_s;

	// Per-channel demand results
	logic [NCH-1:0]      ch_above;
	logic [NCH-1:0]      ch_cool;
	logic [NCH-1:0][7:0] ch_dac;
	logic [NCH-1:0][7:0] ch_pwm;
	logic [7:0]          dac_min;
	logic [7:0]          pwm_min;
	logic [3:0]          pwm_nib;
	logic                monitor;
	logic                auto_dac_en;
	logic                auto_pwm_en;
	logic                auto_on;
	logic                any_above;
	logic                all_cool;
	logic [7:0]          max_dac;
	logic [7:0]          max_pwm;
	logic                cfg_write;

	tfdc_pwm_if pwm_bus ();

	// Address decode, shared by the write and readback paths
	function automatic tfdc_sel_t reg_sel(input logic [7:0] addr);
		tfdc_sel_t sel;
		unique case (addr)
			tfdc_pkg::ADDR_CONFIG:     sel = SEL_CONFIG;
			tfdc_pkg::ADDR_DAC_CODE:   sel = SEL_DAC;
			tfdc_pkg::ADDR_PWM_DUTY:   sel = SEL_PWM;
			tfdc_pkg::ADDR_START_TEMP_LOCAL_LOCAL: sel = SEL_START_TEMP_LOCAL_LOCAL;
			tfdc_pkg::ADDR_START_TEMP_LOCAL_REM_A: sel = SEL_START_TEMP_LOCAL_REM_A;
			tfdc_pkg::ADDR_START_TEMP_LOCAL_REM_B: sel = SEL_START_TEMP_LOCAL_REM_B;
			tfdc_pkg::ADDR_TEST:       sel = SEL_TEST;
			default:                   sel = SEL_NONE;
		endcase
		return sel;
	endfunction : reg_sel

	// Decoded register read, shared by the readback path
	function automatic logic [7:0] reg_read(input logic [7:0] addr, input tfdc_state_t st);
		logic [7:0] test_view;
		test_view = st.test_reg;
		test_view[tfdc_pkg::TEST_PIN_BIT] = st.pin_level;
		unique case (reg_sel(addr))
			SEL_CONFIG:     reg_read = st.cfg;
			SEL_DAC:        reg_read = st.dac_reg;
			SEL_PWM:        reg_read = st.pwm_reg;
			SEL_START_TEMP_LOCAL_LOCAL: reg_read = st.start_temp_local[tfdc_pkg::CHAN_LOCAL];
			SEL_START_TEMP_LOCAL_REM_A: reg_read = st.start_temp_local[tfdc_pkg::CHAN_REMOTE_A];
			SEL_START_TEMP_LOCAL_REM_B: reg_read = st.start_temp_local[tfdc_pkg::CHAN_REMOTE_B];
			SEL_TEST:       reg_read = test_view;
			SEL_NONE:       reg_read = 8'h00;
		endcase
	endfunction : reg_read

	always_comb begin
		monitor     = s.cfg[tfdc_pkg::CFG_MONITOR_BIT];
		auto_dac_en = s.cfg[tfdc_pkg::CFG_AUTO_DAC_BIT];
		auto_pwm_en = s.cfg[tfdc_pkg::CFG_AUTO_PWM_BIT];
		auto_on     = monitor && (auto_dac_en || auto_pwm_en);
		dac_min     = 8'(8'(s.dac_reg[7:4]) * tfdc_pkg::DAC_MIN_STEP);
		pwm_nib     = (auto_dac_en && auto_pwm_en) ? s.dac_reg[7:4] : s.pwm_reg[7:4];
		pwm_min     = 8'(8'(pwm_nib) * tfdc_pkg::PWM_MIN_STEP);
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan
			tfdc_chan_demand u_chan (
				.temp    (s.temp[gi]),
				.start_temp_local    (s.start_temp_local[gi]),
				.dac_min (dac_min),
				.pwm_min (pwm_min),
				.above   (ch_above[gi]),
				.cool    (ch_cool[gi]),
				.dac_dem (ch_dac[gi]),
				.pwm_dem (ch_pwm[gi])
			);
		end
	endgenerate

	always_comb begin
		any_above = |ch_above;
		all_cool  = &ch_cool;
		max_dac   = tfdc_pkg::CODE_OFF;
		max_pwm   = tfdc_pkg::CODE_OFF;
		for (int i = 0; i < NCH; i++) begin
			if (ch_dac[i] > max_dac) begin
				max_dac = ch_dac[i];
			end
			if (ch_pwm[i] > max_pwm) begin
				max_pwm = ch_pwm[i];
			end
		end
	end

	always_comb begin
		next_s     = s;
		next_s.upd = 1'b0;
		cfg_write  = REG_WRITE && (reg_sel(REG_ADDR) == SEL_CONFIG);

		// Register writes
		if (REG_WRITE) begin
			unique case (reg_sel(REG_ADDR))
				SEL_CONFIG:     next_s.cfg = REG_WDATA;
				SEL_DAC:        next_s.dac_reg = REG_WDATA;
				SEL_PWM:        next_s.pwm_reg = REG_WDATA;
				SEL_START_TEMP_LOCAL_LOCAL: next_s.start_temp_local[tfdc_pkg::CHAN_LOCAL] = REG_WDATA;
				SEL_START_TEMP_LOCAL_REM_A: next_s.start_temp_local[tfdc_pkg::CHAN_REMOTE_A] = REG_WDATA;
				SEL_START_TEMP_LOCAL_REM_B: next_s.start_temp_local[tfdc_pkg::CHAN_REMOTE_B] = REG_WDATA;
				SEL_TEST:       next_s.test_reg = REG_WDATA;
				SEL_NONE:       next_s.cfg = s.cfg;
			endcase
		end

		// Clear first so a same-cycle event survives
		if (cfg_write && REG_WDATA[tfdc_pkg::CFG_INT_CLR_BIT]) begin
			next_s.evt = 1'b0;
		end

		if (TEMP_VALID && (TEMP_CHANNEL < 2'(NCH))) begin
			next_s.temp[TEMP_CHANNEL] = TEMP_DATA;
			next_s.upd                = 1'b1;
		end

		if (s.spin) begin
			if (s.spin_cnt == '0) begin
				next_s.spin = 1'b0;
			end else begin
				next_s.spin_cnt = s.spin_cnt - SPIN_W'(1);
			end
		end

		if (!auto_on) begin
			// Leaving automatic mode stops quietly, no event
			next_s.fan_on = 1'b0;
			next_s.spin   = 1'b0;
		end else if (s.upd) begin
			next_s.auto_dac = max_dac;
			next_s.auto_pwm = max_pwm;
			if (!s.fan_on && any_above) begin
				next_s.fan_on   = 1'b1;
				next_s.spin     = 1'b1;
				next_s.spin_cnt = SPIN_W'(SPINUP_CYCLES - 1);
				next_s.evt      = 1'b1;
			end else if (s.fan_on && all_cool) begin
				next_s.fan_on = 1'b0;
				next_s.spin   = 1'b0;
				next_s.evt    = 1'b1;
			end
		end

		// Pin level filter, stage one feeds stage two only
		next_s.pin_sync = {s.pin_sync[1:0], PWM_IN};
		if (s.pin_sync[1] == s.pin_sync[2]) begin
			next_s.pin_level = s.pin_sync[2];
		end

		if (monitor && auto_dac_en) begin
			if (!s.fan_on) begin
				next_s.dac_out = tfdc_pkg::CODE_OFF;
			end else if (s.spin) begin
				next_s.dac_out = tfdc_pkg::CODE_FULL;
			end else begin
				next_s.dac_out = s.auto_dac;
			end
		end else begin
			// code drives 0 to 2.5 V converter
			next_s.dac_out = s.dac_reg;
		end

		if (monitor && auto_pwm_en) begin
			if (!s.fan_on) begin
				next_s.pwm_duty = tfdc_pkg::CODE_OFF;
			end else if (s.spin) begin
				next_s.pwm_duty = tfdc_pkg::CODE_FULL;
			end else begin
				next_s.pwm_duty = s.auto_pwm;
			end
		end else begin
			next_s.pwm_duty = s.pwm_reg;
		end

		next_s.invert  = s.test_reg[tfdc_pkg::TEST_INVERT_BIT];
		next_s.pwm_oe  = pwm_bus.pull;
		next_s.pwm_out = 1'b0;

		next_s.int_n = ~(next_s.evt && next_s.cfg[tfdc_pkg::CFG_INT_EN_BIT]);

		next_s.rdata = reg_read(REG_ADDR, s);
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	assign pwm_bus.duty   = s.pwm_duty;
	assign pwm_bus.invert = s.invert;

	// Prescaler is a parameter so simulation can shorten the period
	tfdc_pwm_gen #(
		.STEP_CYCLES (PWM_STEP)
	) u_pwm (
		.clk     (CLK_SYS),
		.reset_n (RESET_N),
		.pwm     (pwm_bus.gen)
	);

	assign REG_RDATA   = s.rdata;
	assign DAC_CODE    = s.dac_out;
	assign PWM_OUT     = s.pwm_out;
	assign PWM_OE      = s.pwm_oe;
	assign INT_N       = s.int_n;
	assign FAN_RUNNING = s.fan_on;
endmodule : tfdc_core
`default_nettype wire

// [testbench/tfdc_core_monitor.sv]
// Port checker of the fan drive control block
`timescale 1ns/10ps
`default_nettype none
module tfdc_monitor (
	// Clock and reset
	input wire logic       CLK_SYS,
	input wire logic       RESET_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WRITE,
	// Drive outputs
	input wire logic [7:0] DAC_CODE,
	input wire logic       PWM_OUT,
	input wire logic       INT_N,
	input wire logic       FAN_RUNNING
);
	logic [7:0] cfg;
	logic       int_en;
	logic       auto_on;
	logic       auto_dac;
	// Shadow of config, seen only through writes
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N)
			cfg <= 8'h00;
		else if (REG_WRITE && REG_ADDR == 8'h00)
			cfg <= REG_WDATA;
	end
	assign int_en = cfg[1] && !cfg[2];
	assign auto_on = cfg[0] && (cfg[5] || cfg[6]);
	assign auto_dac = cfg[0] && cfg[5];
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	sequence fan_start;
		$rose(FAN_RUNNING) ##0 auto_dac;
	endsequence
	sequence fan_stop;
		$fell(FAN_RUNNING) ##0 auto_dac;
	endsequence
	// Spin-up longer than this window in sim
	sequence spin_full;
		(DAC_CODE == 8'hFF)[*8];
	endsequence
	AST_RESET_VALUES: assert property (
		$rose(RESET_N) |-> DAC_CODE == 8'hFF && INT_N && !FAN_RUNNING)
		else $error("outputs not at reset values");
	AST_OPEN_DRAIN: assert property (PWM_OUT == 1'b0)
		else $error("pulse pin driven high");
	AST_SPINUP: assert property (fan_start |=> spin_full)
		else $error("no full drive after start");
	AST_START_INT: assert property (
		$rose(FAN_RUNNING) && int_en |-> ##[0:1] !INT_N)
		else $error("no interrupt on start");
	AST_STOP_INT: assert property (
		$fell(FAN_RUNNING) && auto_on && int_en |-> ##[0:1] !INT_N)
		else $error("no interrupt on stop");
	AST_INT_MASK: assert property (
		!cfg[1] && $stable(cfg[1]) |-> INT_N)
		else $error("interrupt driven while disabled");
	AST_AUTO_GATE: assert property (!auto_on |-> ##[0:2] !FAN_RUNNING)
		else $error("fan state outside automatic mode");
	AST_MANUAL_DAC: assert property (
		REG_WRITE && REG_ADDR == 8'h04 && !auto_dac |-> ##2 DAC_CODE == $past(REG_WDATA, 2))
		else $error("manual code not applied");
	AST_STOP_OFF: assert property (fan_stop |=> DAC_CODE == 8'h00)
		else $error("drive not off after stop");
endmodule : tfdc_monitor
bind tfdc_core tfdc_monitor u_monitor (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WRITE(REG_WRITE),
	.DAC_CODE(DAC_CODE), .PWM_OUT(PWM_OUT), .INT_N(INT_N), .FAN_RUNNING(FAN_RUNNING));
`default_nettype wire

// [testbench/tfdc_fan_model.sv]
// Fan driver model on the open-drain pulse pin
`timescale 1ns/10ps
`default_nettype none
module tfdc_fan_model (
	// Clock and count control
	input  wire logic   clk,
	input  wire logic   clear,
	// Pin drive from the block
	input  wire logic   pin_out,
	input  wire logic   pin_oe,
	// Resolved pin and on-time count
	output logic        pin,
	output logic [15:0] high_cnt
);
	assign pin = pin_oe ? pin_out : 1'b1;
	always_ff @(posedge clk) begin
		if (clear)
			high_cnt <= 16'h0000;
		else
			high_cnt <= high_cnt + {15'h0000, pin};
	end
endmodule : tfdc_fan_model
`default_nettype wire

// [testbench/thermal_fan_drive_control_bench.sv]
// Self-checking bench of the fan drive control block
`timescale 1ns/10ps
`default_nettype none
module thermal_fan_drive_control_bench;
	localparam int STEP = 2;
	logic        clk_sys = 1'b0;
	logic        reset_n, reg_write, temp_valid, clear, pin;
	logic        pwm_out, pwm_oe, int_n, fan_running;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, temp_data, dac_code;
	logic [1:0]  temp_channel;
	logic [15:0] high_cnt;
	logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h05, 8'h10, 8'h11, 8'h12, 8'h14, 8'h03};
	logic [7:0]  re [8] = '{8'h00, 8'hFF, 8'h00, 8'h7F, 8'h7F, 8'h7F, 8'h00, 8'h00};
	logic [7:0]  dl [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;
	always #20 clk_sys = ~clk_sys;
	// Short spin-up and pulse step keep the run brief
	tfdc_core #(.SPINUP_CYCLES(20), .PWM_STEP(STEP)) uut (.CLK_SYS(clk_sys),
		.RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WRITE(reg_write), .REG_RDATA(reg_rdata), .TEMP_VALID(temp_valid),
		.TEMP_CHANNEL(temp_channel), .TEMP_DATA(temp_data), .DAC_CODE(dac_code),
		.PWM_IN(pin), .PWM_OUT(pwm_out), .PWM_OE(pwm_oe), .INT_N(int_n),
		.FAN_RUNNING(fan_running));
	tfdc_fan_model u_fan (.clk(clk_sys), .clear(clear), .pin_out(pwm_out),
		.pin_oe(pwm_oe), .pin(pin), .high_cnt(high_cnt));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk_sys);
		reg_write = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		repeat (2) @(negedge clk_sys);
		chk(reg_rdata, exp);
	endtask : rd
	task automatic tmp(input logic [1:0] ch, input logic [7:0] d);
		@(negedge clk_sys);
		temp_channel = ch;
		temp_data = d;
		temp_valid = 1'b1;
		@(negedge clk_sys);
		temp_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask : tmp
	// Any 512-cycle window holds exactly one pulse period
	task automatic duty(input logic [15:0] exp);
		repeat (8) @(negedge clk_sys);
		clear = 1'b1;
		@(negedge clk_sys);
		clear = 1'b0;
		repeat (256 * STEP) @(negedge clk_sys);
		chk(high_cnt, exp);
	endtask : duty
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 30000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		{reset_n, reg_write, temp_valid, clear} = 4'h0;
		{reg_addr, reg_wdata, temp_data} = 24'h000000;
		temp_channel = 2'h0;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		reset_n = 1'b1;
		chk(dac_code, 8'hFF);
		chk(int_n, 1'b1);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], re[i]);
		end
		$display("test reset done");
		rd(8'h04, 8'hFF);
		wr(8'h04, 8'h80);
		rd(8'h04, 8'h80);
		chk(dac_code, 8'h80);
		for (int i = 0; i < 4; i++) begin
			wr(8'h05, dl[i]);
			duty((dl[i] == 8'hFF) ? 16'h0200 : 16'(dl[i]) * 16'(STEP));
		end
		wr(8'h14, 8'h02);
		duty(16'h0000);
		rd(8'h14, 8'h02);
		wr(8'h05, 8'h01);
		duty(16'h01FE);
		wr(8'h14, 8'h00);
		wr(8'h05, 8'hFF);
		duty(16'h0200);
		rd(8'h14, 8'h80);
		wr(8'h05, 8'h00);
		$display("test manual done");
		wr(8'h04, 8'h40);
		wr(8'h10, 8'h10);
		wr(8'h00, 8'h23);
		tmp(2'h0, 8'h1A);
		chk(fan_running, 1'b1);
		chk(int_n, 1'b0);
		chk(dac_code, 8'hFF);
		repeat (30) @(negedge clk_sys);
		chk(dac_code, 8'h98);
		wr(8'h00, 8'h27);
		wr(8'h00, 8'h23);
		chk(int_n, 1'b1);
		$display("test start done");
		wr(8'h12, 8'h10);
		tmp(2'h2, 8'h30);
		chk(dac_code, 8'hFF);
		tmp(2'h2, 8'h14);
		chk(dac_code, 8'h98);
		tmp(2'h1, 8'h7F);
		tmp(2'h3, 8'h7F);
		chk(dac_code, 8'h98);
		$display("test highest done");
		tmp(2'h1, 8'h7B);
		tmp(2'h2, 8'h0C);
		tmp(2'h0, 8'h0D);
		chk(fan_running, 1'b1);
		chk(dac_code, 8'h40);
		tmp(2'h0, 8'h80);
		chk(fan_running, 1'b0);
		chk(int_n, 1'b0);
		chk(dac_code, 8'h00);
		$display("test stop done");
		wr(8'h00, 8'h20);
		chk(int_n, 1'b1);
		tmp(2'h0, 8'h30);
		chk(fan_running, 1'b0);
		chk(dac_code, 8'h40);
		$display("test gate done");
		wr(8'h04, 8'hF0);
		wr(8'h00, 8'h61);
		tmp(2'h0, 8'h11);
		chk(fan_running, 1'b1);
		chk(dac_code, 8'hFF);
		repeat (30) @(negedge clk_sys);
		chk(dac_code, 8'hF0);
		duty(16'h0200);
		wr(8'h00, 8'h41);
		wr(8'h05, 8'h80);
		tmp(2'h0, 8'h11);
		repeat (30) @(negedge clk_sys);
		duty(16'h011A);
		$display("test pulse auto done");
		end_of_test();
	end
endmodule : thermal_fan_drive_control_bench
`default_nettype wire
